// ---- src/tpg_regs.svh ----
// register offsets, reset values and counts of the test pattern unit
// assumes inclusion by bare name from the design files and the bench
`ifndef TPG_REGS_SVH
`define TPG_REGS_SVH

// register offsets
`define TPG_CTRL_ADDR    8'h08
`define TPG_ROUTE_ADDR   8'h09
`define TPG_STAT_ADDR    8'h0a

// reset values (none documented, all cleared)
`define TPG_CTRL_RST     8'h00
`define TPG_ROUTE_RST    8'h00
`define TPG_RDATA_NONE   8'h00

// sync and error counting
`define TPG_SYNC_MATCHES 6'h20
`define TPG_LOSS_MISSES  4'h8
`define TPG_ERR_MAX      7'h7f

// framing: bit positions in a frame, multiframe length, framing words
`define TPG_DS1_LAST     8'hc0
`define TPG_E1_LAST      8'hff
`define TPG_E1_OVH_BITS  8'h08
`define TPG_E1_MSB       3'h7
`define TPG_SF_LAST      4'hb
`define TPG_SF_PATTERN   12'h8dc
`define TPG_E1_FAS       8'h9b
`define TPG_E1_NFAS      8'hdf

// drop source code that selects the test pattern
`define TPG_TRIB_INSERT  5'h1f

// sequence generator taps (stage numbers), seed and zero limit window
`define TPG_TAP15_A      14
`define TPG_TAP15_B      13
`define TPG_TAP20_A      19
`define TPG_TAP20_B      2
`define TPG_TAP23_A      22
`define TPG_TAP23_B      17
`define TPG_TAPQR_A      19
`define TPG_TAPQR_B      16
`define TPG_LFSR_SEED    23'h7fffff
`define TPG_QRSS_ZMASK   23'h003fff

`endif

// ---- src/tpg_pkg.sv ----
// types shared by the test pattern unit
// assumes nothing beyond a SystemVerilog compiler
package tpg_pkg;

	// sequence select code, shared by generator and detector
	typedef enum logic [1:0] {
		SEQ_P15  = 2'b00,
		SEQ_P20  = 2'b01,
		SEQ_P23  = 2'b10,
		SEQ_QRSS = 2'b11
	} tpg_seq_e;

	// detector sync state
	typedef enum logic {
		SYNC_HUNT = 1'b0,
		SYNC_LOCK = 1'b1
	} tpg_sync_e;

	// control register layout, bit 7 first
	typedef struct packed {
		logic     error_count_clear;
		logic     det_framed_en;
		tpg_seq_e det_sequence_sel;
		logic     single_error_inject;
		logic     gen_framed_en;
		tpg_seq_e gen_sequence_sel;
	} tpg_ctrl_s;

	// routing register layout, bit 7 first
	typedef struct packed {
		logic       framing_format_sel;
		logic       sequence_invert;
		logic       insert_direction_sel;
		logic [4:0] insert_tributary_sel;
	} tpg_route_s;

	// status register layout, bit 7 first
	typedef struct packed {
		logic       det_out_of_sync;
		logic [6:0] det_error_count;
	} tpg_stat_s;

	// one tributary bit with its strobe
	typedef struct packed {
		logic data;
		logic stb;
	} tpg_trib_s;

	typedef logic [4:0] tpg_srcsel_t;

endpackage

// ---- src/tpg_lfsr.sv ----
// shift register sequence source for the four test sequences
// assumes strobes from logic on the same clock
`timescale 1ns/1ps
`include "tpg_regs.svh"

module tpg_lfsr (
	input  wire logic             i_clk,
	input  wire logic             i_reset_n,
	input  wire logic             i_adv,
	input  wire logic             i_load,
	input  wire logic             i_load_bit,
	input  wire tpg_pkg::tpg_seq_e i_sel,
	output logic                  o_bit
);
	import tpg_pkg::*;

	logic [22:0] s_r;
	logic [22:0] s_nxt;
	logic        fb;
	logic        zero_run;

	// feedback per sequence; newest bit sits in stage 0
	assign fb = (i_sel == SEQ_P15)  ? s_r[`TPG_TAP15_A] ^ s_r[`TPG_TAP15_B] :
	            (i_sel == SEQ_P20)  ? s_r[`TPG_TAP20_A] ^ s_r[`TPG_TAP20_B] :
	            (i_sel == SEQ_P23)  ? s_r[`TPG_TAP23_A] ^ s_r[`TPG_TAP23_B] :
	                                  s_r[`TPG_TAPQR_A] ^ s_r[`TPG_TAPQR_B];
	// quasi-random: force a one after fourteen zeros
	assign zero_run = (s_r & `TPG_QRSS_ZMASK) == 23'h000000;
	assign o_bit    = fb | ((i_sel == SEQ_QRSS) & zero_run);
	// load takes received bits while hunting, else free run
	assign s_nxt    = {s_r[21:0], i_load ? i_load_bit : fb};

	// state update on each advance
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			s_r <= `TPG_LFSR_SEED;
		end else if (i_adv) begin
			s_r <= s_nxt;
		end
	end

endmodule

// ---- src/tpg_top.sv ----
// test pattern generator and detector for the tributary data paths
// assumes tributary strobes and data come from logic on I_MCLK
`timescale 1ns/1ps
`include "tpg_regs.svh"

module tpg_top #(
	parameter int N_TRIB = 28
) (
	input  wire logic                I_MCLK,
	input  wire logic                I_RESET_N,
	input  wire logic [7:0]          I_REG_ADDR,
	input  wire logic                I_REG_WR,
	input  wire logic [7:0]          I_REG_WDATA,
	output logic [7:0]               O_REG_RDATA,
	input  wire tpg_pkg::tpg_trib_s  I_TX_IN [N_TRIB],
	output tpg_pkg::tpg_trib_s       O_TX_OUT [N_TRIB],
	input  wire tpg_pkg::tpg_trib_s  I_RX_IN [N_TRIB],
	output tpg_pkg::tpg_trib_s       O_RX_OUT [N_TRIB],
	input  wire tpg_pkg::tpg_srcsel_t I_TRIB_SRC_SEL [N_TRIB]
);
	import tpg_pkg::*;

	localparam logic [4:0] NT5 = 5'(N_TRIB);
	// superframe framing word, indexed by frame number in the multiframe
	localparam logic [11:0] SF_WORD = `TPG_SF_PATTERN;

	// refuse a tributary count outside 1 to 28, though the five-bit selector reaches 31
	if (N_TRIB < 1 || N_TRIB > 28) begin : g_bad_ntrib
		$error("tpg_top: N_TRIB must be 1 to 28");
	end

	// registers
	tpg_ctrl_s   ctrl_r;
	tpg_route_s  route_r;
	logic [7:0]  rdata_r;
	logic        clr_d_r;
	logic        inj_d_r;
	logic        inj_pend_r;
	logic [7:0]  gen_pos_r;
	logic [3:0]  gen_mf_r;
	logic [7:0]  det_pos_r;
	tpg_sync_e   sync_r;
	logic [5:0]  mcnt_r;
	logic [3:0]  miss_r;
	logic [6:0]  err_r;

	// decoded and selected signals
	logic              ctrl_wr;
	logic              route_wr;
	logic [7:0]        rdata_nxt;
	logic              clr_edge;
	logic              inj_edge;
	logic              trib_ok;
	logic [4:0]        trib_idx;
	logic [N_TRIB-1:0] tx_hit;
	logic [N_TRIB-1:0] rx_hit;
	logic [N_TRIB-1:0] tx_stb_v;
	logic [N_TRIB-1:0] rx_stb_v;
	logic [N_TRIB-1:0] tx_dat_v;
	logic [N_TRIB-1:0] rx_dat_v;
	logic              mon_stb;
	logic              mon_data;
	logic              gen_adv;
	logic              gen_ovh;
	logic              gen_last;
	logic              gen_fbit;
	logic [7:0]        e1_word;
	logic              lfsr_bit;
	logic              gen_bit;
	logic              rcv_bit;
	logic              det_ovh;
	logic              det_last;
	logic              det_take;
	logic              exp_bit;
	logic              det_match;
	logic              det_hunt;
	logic              mcnt_done;
	logic              miss_done;
	logic              det_slip;
	logic              err_full;

	// register port decode and read selection
	assign ctrl_wr   = I_REG_WR && (I_REG_ADDR == `TPG_CTRL_ADDR);
	assign route_wr  = I_REG_WR && (I_REG_ADDR == `TPG_ROUTE_ADDR);
	assign rdata_nxt = (I_REG_ADDR == `TPG_CTRL_ADDR)  ? ctrl_r :
	                   (I_REG_ADDR == `TPG_ROUTE_ADDR) ? route_r :
	                   (I_REG_ADDR == `TPG_STAT_ADDR)  ?
	                   {sync_r == SYNC_HUNT, err_r} : `TPG_RDATA_NONE;
	assign O_REG_RDATA = rdata_r;

	// control and routing registers, read data register
	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			ctrl_r  <= tpg_ctrl_s'(`TPG_CTRL_RST);
			route_r <= tpg_route_s'(`TPG_ROUTE_RST);
			rdata_r <= `TPG_RDATA_NONE;
			clr_d_r <= 1'b0;
			inj_d_r <= 1'b0;
		end else begin
			if (ctrl_wr) begin
				ctrl_r <= tpg_ctrl_s'(I_REG_WDATA);
			end
			if (route_wr) begin
				route_r <= tpg_route_s'(I_REG_WDATA);
			end
			rdata_r <= rdata_nxt;
			clr_d_r <= ctrl_r.error_count_clear;
			inj_d_r <= ctrl_r.single_error_inject;
		end
	end

	// rising edges of the clear and inject bits
	assign clr_edge = ctrl_r.error_count_clear & ~clr_d_r;
	assign inj_edge = ctrl_r.single_error_inject & ~inj_d_r;

	// tributary number 1..N_TRIB names a path, others name none
	assign trib_ok  = (route_r.insert_tributary_sel != 5'h00) &&
	                  (route_r.insert_tributary_sel <= NT5);
	assign trib_idx = route_r.insert_tributary_sel - 5'h01;

	// per tributary selection and registered substitution
	for (genvar i = 0; i < N_TRIB; i++) begin : g_trib
		assign tx_hit[i]   = trib_ok && (trib_idx == 5'(i)) &&
		                     !route_r.insert_direction_sel;
		assign rx_hit[i]   = trib_ok && (trib_idx == 5'(i)) &&
		                     route_r.insert_direction_sel;
		assign tx_stb_v[i] = I_TX_IN[i].stb;
		assign rx_stb_v[i] = I_RX_IN[i].stb;
		assign tx_dat_v[i] = I_TX_IN[i].data;
		assign rx_dat_v[i] = I_RX_IN[i].data;

		// pattern replaces the chosen path or a pattern-sourced drop
		always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
			if (!I_RESET_N) begin
				O_TX_OUT[i] <= '0;
				O_RX_OUT[i] <= '0;
			end else begin
				O_TX_OUT[i].stb  <= I_TX_IN[i].stb;
				O_TX_OUT[i].data <= tx_hit[i] ? gen_bit
				                    : I_TX_IN[i].data;
				O_RX_OUT[i].stb  <= I_RX_IN[i].stb;
				O_RX_OUT[i].data <= (rx_hit[i] ||
				   I_TRIB_SRC_SEL[i] == `TPG_TRIB_INSERT) ? gen_bit
				   : I_RX_IN[i].data;
			end
		end
	end

	// monitored path: bits from before substitution
	assign mon_stb  = |(tx_hit & tx_stb_v) | |(rx_hit & rx_stb_v);
	assign mon_data = |(tx_hit & tx_stb_v & tx_dat_v) |
	                  |(rx_hit & rx_stb_v & rx_dat_v);
	assign gen_adv  = mon_stb;

	// framing positions: one bit per DS1 frame, eight bits per E1 frame
	function automatic logic ovh_f(input logic ds1, input logic [7:0] pos);
		ovh_f = ds1 ? (pos == 8'h00) : (pos < `TPG_E1_OVH_BITS);
	endfunction

	function automatic logic last_f(input logic ds1, input logic [7:0] pos);
		last_f = ds1 ? (pos == `TPG_DS1_LAST) : (pos == `TPG_E1_LAST);
	endfunction

	// generator framing bit selection
	assign gen_ovh  = ctrl_r.gen_framed_en &&
	                  ovh_f(route_r.framing_format_sel, gen_pos_r);
	assign gen_last = last_f(route_r.framing_format_sel, gen_pos_r);
	assign e1_word  = gen_mf_r[0] ? `TPG_E1_NFAS : `TPG_E1_FAS;
	assign gen_fbit = route_r.framing_format_sel
	                  ? SF_WORD[`TPG_SF_LAST - gen_mf_r]
	                  : e1_word[`TPG_E1_MSB - gen_pos_r[2:0]];

	// generator sequence source
	tpg_lfsr u_gen (
		.i_clk      (I_MCLK),
		.i_reset_n  (I_RESET_N),
		.i_adv      (gen_adv && !gen_ovh),
		.i_load     (1'b0),
		.i_load_bit (1'b0),
		.i_sel      (ctrl_r.gen_sequence_sel),
		.o_bit      (lfsr_bit)
	);

	// pattern bit: framing, or sequence with inversion and one error
	assign gen_bit = gen_ovh ? gen_fbit
	                 : lfsr_bit ^ route_r.sequence_invert
	                   ^ inj_pend_r;

	// generator frame counters and pending error
	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			gen_pos_r  <= 8'h00;
			gen_mf_r   <= 4'h0;
			inj_pend_r <= 1'b0;
		end else begin
			if (gen_adv) begin
				gen_pos_r <= gen_last ? 8'h00 : gen_pos_r + 8'h01;
				if (gen_last) begin
					gen_mf_r <= (gen_mf_r == `TPG_SF_LAST) ? 4'h0
					            : gen_mf_r + 4'h1;
				end
			end
			// set wins over consumption in the same cycle
			inj_pend_r <= inj_edge |
			              (inj_pend_r & ~(gen_adv & ~gen_ovh));
		end
	end

	// detector input and framing skip
	assign rcv_bit  = mon_data ^ route_r.sequence_invert;
	assign det_ovh  = ctrl_r.det_framed_en &&
	                  ovh_f(route_r.framing_format_sel, det_pos_r);
	assign det_last = last_f(route_r.framing_format_sel, det_pos_r);
	assign det_take = mon_stb && !det_ovh;
	assign det_hunt = (sync_r == SYNC_HUNT);

	// reference: fed with received bits while hunting, free when locked
	tpg_lfsr u_ref (
		.i_clk      (I_MCLK),
		.i_reset_n  (I_RESET_N),
		.i_adv      (det_take),
		.i_load     (det_hunt),
		.i_load_bit (rcv_bit),
		.i_sel      (ctrl_r.det_sequence_sel),
		.o_bit      (exp_bit)
	);

	assign det_match = (exp_bit == rcv_bit);
	assign mcnt_done = (mcnt_r == `TPG_SYNC_MATCHES - 6'h01);
	assign miss_done = (miss_r == `TPG_LOSS_MISSES - 4'h1);
	assign err_full  = (err_r == `TPG_ERR_MAX);
	// framed hunt slips one bit on a mismatch to find the frame
	assign det_slip  = det_hunt && det_take && !det_match &&
	                   ctrl_r.det_framed_en;

	// detector frame position
	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			det_pos_r <= 8'h00;
		end else if (mon_stb && !det_slip) begin
			det_pos_r <= det_last ? 8'h00 : det_pos_r + 8'h01;
		end
	end

	// sync state machine with match and miss counters
	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			sync_r <= SYNC_HUNT;
			mcnt_r <= 6'h00;
			miss_r <= 4'h0;
		end else if (det_take) begin
			unique case (sync_r)
				SYNC_HUNT: begin
					miss_r <= 4'h0;
					if (!det_match) begin
						mcnt_r <= 6'h00;
					end else if (mcnt_done) begin
						mcnt_r <= 6'h00;
						sync_r <= SYNC_LOCK;
					end else begin
						mcnt_r <= mcnt_r + 6'h01;
					end
				end
				SYNC_LOCK: begin
					mcnt_r <= 6'h00;
					if (det_match) begin
						miss_r <= 4'h0;
					end else if (miss_done) begin
						miss_r <= 4'h0;
						sync_r <= SYNC_HUNT;
					end else begin
						miss_r <= miss_r + 4'h1;
					end
				end
			endcase
		end
	end

	// saturating error counter, clear edge has priority
	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			err_r <= 7'h00;
		end else if (clr_edge) begin
			err_r <= 7'h00;
		end else if (!det_hunt && det_take && !det_match && !err_full) begin
			err_r <= err_r + 7'h01;
		end
	end

	// checks on the detector, counter, generator and path substitution
	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (!I_RESET_N);

	property p_lock_32;
		$rose(sync_r == SYNC_LOCK) |-> $past(mcnt_r) == 6'h1f;
	endproperty
	a_lock_32: assert property (p_lock_32)
		else $error("lock without 32 matches");

	property p_lose_8;
		$fell(sync_r == SYNC_LOCK) |->
			$past(miss_r) == 4'h7 && $past(det_take && !det_match);
	endproperty
	a_lose_8: assert property (p_lose_8)
		else $error("sync lost without 8 mismatches");

	property p_err_hunt;
		(det_hunt && !clr_edge) |=> $stable(err_r);
	endproperty
	a_err_hunt: assert property (p_err_hunt)
		else $error("error count moved out of sync");

	property p_err_inc;
		(!det_hunt && det_take && !det_match && !err_full && !clr_edge)
			|=> err_r == $past(err_r) + 7'h01;
	endproperty
	a_err_inc: assert property (p_err_inc)
		else $error("mismatch not counted");

	property p_err_sat;
		(err_full && !clr_edge) |=> err_full;
	endproperty
	a_err_sat: assert property (p_err_sat)
		else $error("error count left maximum");

	property p_clr;
		$rose(ctrl_r.error_count_clear) |=> err_r == 7'h00;
	endproperty
	a_clr: assert property (p_clr)
		else $error("error count not cleared");

	property p_inject;
		(inj_pend_r && gen_adv && !gen_ovh) |->
			gen_bit != (lfsr_bit ^ route_r.sequence_invert)
			##1 !inj_pend_r || $past(inj_edge);
	endproperty
	a_inject: assert property (p_inject)
		else $error("inject did not flip exactly one bit");

	property p_unframed;
		(!ctrl_r.gen_framed_en && !inj_pend_r) |->
			gen_bit == (lfsr_bit ^ route_r.sequence_invert);
	endproperty
	a_unframed: assert property (p_unframed)
		else $error("framing bit in unframed pattern");

	property p_drop_insert;
		(I_TRIB_SRC_SEL[N_TRIB-1] == `TPG_TRIB_INSERT) |=>
			O_RX_OUT[N_TRIB-1].data == $past(gen_bit);
	endproperty
	a_drop_insert: assert property (p_drop_insert)
		else $error("pattern not on pattern-sourced output");

	property p_tx_subst;
		tx_hit[0] |=> O_TX_OUT[0].data == $past(gen_bit);
	endproperty
	a_tx_subst: assert property (p_tx_subst)
		else $error("pattern not on selected transmit path");

	c_lock: cover property ($rose(sync_r == SYNC_LOCK));
	c_lose: cover property ($fell(sync_r == SYNC_LOCK));
	c_sat: cover property ($rose(err_full));
	c_inject: cover property (inj_pend_r && gen_adv && !gen_ovh);

endmodule

// ---- verification/tpg_trib_partner.sv ----
// tributary source that loops the unit's own pattern back into it
// assumes one clock with the unit; strobes launched on falling edges
`timescale 1ns/1ps

module tpg_trib_partner (
	input  wire logic               i_clk,
	input  wire logic [3:0]         i_gap,
	input  wire logic               i_invert,
	input  wire tpg_pkg::tpg_trib_s i_ret,
	output tpg_pkg::tpg_trib_s      o_trib
);
	import tpg_pkg::*;
	logic       last_r;
	logic [3:0] cnt_r;

	// remember the last bit the unit sent out on the looped path
	always @(posedge i_clk) begin
		if (i_ret.stb)
			last_r <= i_ret.data;
	end

	// one strobe per gap+1 cycles; idle data toggles, never stale
	always @(negedge i_clk) begin
		if (cnt_r >= i_gap) begin
			cnt_r  <= 4'h0;
			o_trib <= '{data: last_r ^ i_invert, stb: 1'b1};
		end else begin
			cnt_r  <= cnt_r + 4'h1;
			o_trib <= '{data: ~o_trib.data, stb: 1'b0};
		end
	end

	// start quiet
	initial begin
		last_r = 1'b0;
		cnt_r  = 4'h0;
		o_trib = '0;
	end
endmodule

// ---- verification/tb_top.sv ----
// self-checking bench for the test pattern unit with two tributaries
// assumes tpg_top, tpg_pkg and the loop-back partner on tributary 0
`timescale 1ns/1ps
`include "tpg_regs.svh"

module tb_top;
	import tpg_pkg::*;
	logic            clk;
	logic            rst_n;
	logic [7:0]      addr;
	logic            wr;
	logic [7:0]      wdata;
	logic [7:0]      rdata;
	logic [7:0]      rd;
	tpg_trib_s       tx1;
	tpg_trib_s       rx1;
	tpg_trib_s       p_trib;
	tpg_trib_s       p_ret;
	wire tpg_trib_s  tx_in [2];
	wire tpg_trib_s  rx_in [2];
	tpg_trib_s       tx_out [2];
	tpg_trib_s       rx_out [2];
	tpg_srcsel_t     src_sel [2];
	logic            side_rx;
	logic            p_inv;
	logic [3:0]      p_gap;
	int              n_mismatch;
	int              check_count;
	int              i;
	int              ones;
	logic            q [$];
	logic [7:0]      ra [4] = '{8'h08, 8'h09, 8'h0a, 8'h0b};
	logic [7:0]      re [4] = '{8'h00, 8'h00, 8'h80, 8'h00};
	logic [7:0]      tc [7] = '{8'h00, 8'h11, 8'h22, 8'h33, 8'h44, 8'h44, 8'h00};
	logic [7:0]      tr [7] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h81, 8'h01, 8'h21};

	// partner sits on tributary 0, transmit or receive side
	assign tx_in[0] = side_rx ? tpg_trib_s'(2'b00) : p_trib;
	assign rx_in[0] = side_rx ? p_trib : tpg_trib_s'(2'b00);
	assign tx_in[1] = tx1;
	assign rx_in[1] = rx1;
	assign p_ret    = side_rx ? rx_out[0] : tx_out[0];

	always #25 clk = ~clk;

	tpg_top #(.N_TRIB(2)) u_tpg_top (
		.I_MCLK(clk), .I_RESET_N(rst_n), .I_REG_ADDR(addr),
		.I_REG_WR(wr), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata),
		.I_TX_IN(tx_in), .O_TX_OUT(tx_out), .I_RX_IN(rx_in),
		.O_RX_OUT(rx_out), .I_TRIB_SRC_SEL(src_sel)
	);

	tpg_trib_partner u_tpg_trib_partner (
		.i_clk(clk), .i_gap(p_gap), .i_invert(p_inv), .i_ret(p_ret),
		.o_trib(p_trib)
	);

	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk8(input string name, input logic [7:0] exp,
		input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr  = a;
		wr    = 1'b1;
		wdata = d;
		@(negedge clk);
		wr = 1'b0;
	endtask

	// read data is registered one edge after the address
	task automatic rd_reg(input logic [7:0] a);
		@(negedge clk);
		addr = a;
		@(negedge clk);
		rd = rdata;
	endtask

	// poll status until the sync flag reaches exp, bounded
	task automatic wait_oos(input logic exp, input int max_rd);
		for (int k = 0; k < max_rd; k++) begin
			rd_reg(`TPG_STAT_ADDR);
			if (rd[7] === exp)
				break;
		end
		chk8("sync flag", {exp, 7'h00}, {rd[7], 7'h00});
	endtask

	// capture 60 generated bits and check the 15-stage recurrence
	task automatic chk_seq(input logic inv);
		logic e;
		q = {};
		repeat (4) @(negedge clk);
		while (q.size() < 60) begin
			@(negedge clk);
			if (tx_out[0].stb === 1'b1)
				q.push_back(tx_out[0].data);
		end
		for (int n = 15; n < 60; n++) begin
			e = q[n-14] ^ q[n-15] ^ inv;
			chk8("sequence bit", {7'h00, e}, {7'h00, q[n]});
		end
	endtask

	// drive one strobe on tributary 1 both sides, then idle with inverted data
	task automatic strobe1(input logic d);
		@(negedge clk);
		tx1 = '{data: d, stb: 1'b1};
		rx1 = '{data: d, stb: 1'b1};
		@(negedge clk);
		tx1 = '{data: ~d, stb: 1'b0};
		rx1 = '{data: ~d, stb: 1'b0};
	endtask

	// hang guard, 60k cycles, above the sum of all bounded waits
	initial begin
		#3000000;
		n_mismatch++;
		test_done();
	end

	initial begin
		clk         = 1'b0;
		rst_n       = 1'b0;
		addr        = 8'h00;
		wr          = 1'b0;
		wdata       = 8'h00;
		tx1         = '0;
		rx1         = '0;
		src_sel[0]  = 5'h00;
		src_sel[1]  = 5'h00;
		side_rx     = 1'b0;
		p_inv       = 1'b0;
		p_gap       = 4'h1;
		n_mismatch  = 0;
		check_count = 0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		// reset values, writes to status and unmapped are ignored
		wr_reg(`TPG_STAT_ADDR, 8'hff);
		wr_reg(8'h0b, 8'hff);
		for (i = 0; i < 4; i++) begin
			rd_reg(ra[i]);
			chk8("register", re[i], rd);
		end
		// loop pattern on transmit tributary 1, same sequence both ends
		wr_reg(`TPG_ROUTE_ADDR, 8'h01);
		rd_reg(`TPG_ROUTE_ADDR);
		chk8("routing", 8'h01, rd);
		wait_oos(1'b0, 400);
		chk_seq(1'b0);
		wr_reg(`TPG_ROUTE_ADDR, 8'h41);
		chk_seq(1'b1);
		wr_reg(`TPG_ROUTE_ADDR, 8'h01);
		wait_oos(1'b0, 400);
		// clear, single inject, saturation, clear again
		wr_reg(`TPG_CTRL_ADDR, 8'h80);
		wr_reg(`TPG_CTRL_ADDR, 8'h00);
		rd_reg(`TPG_STAT_ADDR);
		chk8("status", 8'h00, rd);
		wr_reg(`TPG_CTRL_ADDR, 8'h08);
		wr_reg(`TPG_CTRL_ADDR, 8'h00);
		repeat (20) @(negedge clk);
		rd_reg(`TPG_STAT_ADDR);
		chk8("status", 8'h01, rd);
		repeat (130) begin
			wr_reg(`TPG_CTRL_ADDR, 8'h08);
			wr_reg(`TPG_CTRL_ADDR, 8'h00);
			repeat (16) @(negedge clk);
		end
		rd_reg(`TPG_STAT_ADDR);
		chk8("status", {1'b0, `TPG_ERR_MAX}, rd);
		wr_reg(`TPG_CTRL_ADDR, 8'h80);
		rd_reg(`TPG_STAT_ADDR);
		chk8("status", 8'h00, rd);
		// different sequences at the two ends never reach sync
		p_inv = 1'b1;
		wait_oos(1'b1, 40);
		p_inv = 1'b0;
		wr_reg(`TPG_CTRL_ADDR, 8'h10);
		repeat (600) @(negedge clk);
		rd_reg(`TPG_STAT_ADDR);
		chk8("sync flag", 8'h80, {rd[7], 7'h00});
		// every code, framed DS1 and E1, receive side with slow strobes
		for (i = 0; i < 7; i++) begin
			p_inv = 1'b1;
			wait_oos(1'b1, 40);
			side_rx = tr[i][5];
			p_gap   = tr[i][5] ? 4'h5 : 4'h1;
			wr_reg(`TPG_ROUTE_ADDR, tr[i]);
			wr_reg(`TPG_CTRL_ADDR, tc[i]);
			p_inv = 1'b0;
			wait_oos(1'b0, 3000);
		end
		// pass-through on tributary 1, then pattern insertion by code
		side_rx = 1'b0;
		p_gap   = 4'h1;
		wr_reg(`TPG_ROUTE_ADDR, 8'h01);
		strobe1(1'b1);
		chk8("tx pass", 8'h03, {6'h00, tx_out[1]});
		chk8("rx pass", 8'h03, {6'h00, rx_out[1]});
		src_sel[1] = `TPG_TRIB_INSERT;
		ones = 0;
		repeat (40) begin
			strobe1(1'b0);
			if (rx_out[1].data === 1'b1)
				ones++;
		end
		chk8("inserted ones", 8'h01, {7'h00, ones > 0});
		test_done();
	end
endmodule
